// ===== logic/bbx_exec_unit.sv
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "bbx_defs.svh"

module bbx_exec_unit (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Instruction port
	input wire bbx_pkg::bbx_req_t instr,
	output logic instr_ready,
	output logic op_done,
	// Register port
	input wire bbx_pkg::bbx_bus_t bus,
	output logic [7:0] rd_data
);

	// Opcode decode, used only by the field latch on acceptance
	function automatic bbx_pkg::bbx_op_t decode_op(input logic [13:0] w);
		bbx_pkg::bbx_op_t op;
		op = bbx_pkg::OP_NONE;
		if (w[`BBX_OPC_MSB:`BBX_OPC_LSB] == `BBX_OPC_ADD) begin
			op = bbx_pkg::OP_ADD;
		end else if (w[`BBX_OPC_MSB:`BBX_OPC_LSB] == `BBX_OPC_AND) begin
			op = bbx_pkg::OP_AND;
		end else if (w[`BBX_OPC_MSB:`BBX_BOPC_LSB] == `BBX_BOPC_CLR) begin
			op = bbx_pkg::OP_CLR;
		end else if (w[`BBX_OPC_MSB:`BBX_BOPC_LSB] == `BBX_BOPC_SET) begin
			op = bbx_pkg::OP_SET;
		end
		return op;
	endfunction

	// Address decode for the file register window
	function automatic logic is_file(input logic [7:0] a);
		return a[`BBX_FILE_SEL_BIT];
	endfunction

	bbx_pkg::bbx_state_t state;
	bbx_pkg::bbx_op_t cur_op;
	logic cur_dest;
	logic [6:0] cur_addr;
	logic [2:0] cur_bpos;
	logic [7:0] acc;
	bbx_pkg::bbx_flags_t flags;
	logic flag_c, flag_dc, flag_z, flag_ill;
	logic [7:0] op_count;
	logic [7:0] reg_rdata;
	logic rd_file;

	logic accept;
	logic exec;
	logic mem_re;
	logic [6:0] mem_raddr;
	logic [7:0] mem_rdata;
	logic mem_we;
	logic [6:0] mem_waddr;
	logic [7:0] mem_wdata;

	logic [8:0] sum9;
	logic [4:0] half5;
	logic [7:0] and_v;
	logic [7:0] bit_result;
	logic [7:0] result;
	logic byte_op;
	logic exec_acc_we;
	logic exec_file_we;
	logic sw_acc_we;
	logic sw_flags_we;
	logic sw_file_we;

	// A file read from software owns the read port, so no instruction that cycle
	assign instr_ready = (state == bbx_pkg::ST_IDLE) && !(bus.rd && is_file(bus.addr));
	assign accept = instr.valid && instr_ready;
	assign exec = (state == bbx_pkg::ST_EXEC);

	// Sequencer: accept cycle reads the operand, execute cycle writes back
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= bbx_pkg::ST_IDLE;
		end else begin
			unique case (state)
				bbx_pkg::ST_IDLE: begin
					if (accept) begin
						state <= bbx_pkg::ST_EXEC;
					end
				end
				bbx_pkg::ST_EXEC: begin
					state <= bbx_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Latch decoded fields on acceptance
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_op <= bbx_pkg::OP_NONE;
			cur_dest <= 1'b0;
			cur_addr <= 7'h00;
			cur_bpos <= 3'h0;
		end else if (accept) begin
			cur_op <= decode_op(instr.word);
			cur_dest <= instr.word[`BBX_DEST_BIT];
			cur_addr <= instr.word[`BBX_ADDR_MSB:0];
			cur_bpos <= instr.word[`BBX_BPOS_MSB:`BBX_BPOS_LSB];
		end
	end

	// Done pulse lands in the cycle the results first read back
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_done <= 1'b0;
		end else begin
			op_done <= exec;
		end
	end

	// Operand read: instruction address on acceptance, else software address
	assign mem_re = accept || (bus.rd && is_file(bus.addr));
	assign mem_raddr = accept ? instr.word[`BBX_ADDR_MSB:0] : bus.addr[6:0];

	// Arithmetic on the operand held in the memory read register
	assign sum9 = {1'b0, acc} + {1'b0, mem_rdata};
	assign half5 = {1'b0, acc[3:0]} + {1'b0, mem_rdata[3:0]};
	assign and_v = acc & mem_rdata;

	// Bit modify: only the selected lane changes
	for (genvar gi = 0; gi < 8; gi++) begin : g_bit
		assign bit_result[gi] = (cur_bpos == 3'(gi)) ?
			(cur_op == bbx_pkg::OP_SET) : mem_rdata[gi];
	end

	// Result select
	always_comb begin
		unique case (cur_op)
			bbx_pkg::OP_ADD: result = sum9[7:0];
			bbx_pkg::OP_AND: result = and_v;
			bbx_pkg::OP_CLR, bbx_pkg::OP_SET: result = bit_result;
			default: result = mem_rdata;
		endcase
	end

	// Destination steering
	assign byte_op = (cur_op == bbx_pkg::OP_ADD) || (cur_op == bbx_pkg::OP_AND);
	assign exec_acc_we = exec && byte_op && !cur_dest;
	assign exec_file_we = exec && ((byte_op && cur_dest) ||
		(cur_op == bbx_pkg::OP_CLR) || (cur_op == bbx_pkg::OP_SET));

	// Software writes; the executing instruction wins any collision
	assign sw_acc_we = bus.wr && (bus.addr == `BBX_REG_ACC) && !exec_acc_we;
	assign sw_flags_we = bus.wr && (bus.addr == `BBX_REG_FLAGS);
	assign sw_file_we = bus.wr && is_file(bus.addr) && !exec_file_we;

	// Memory write port
	assign mem_we = exec_file_we || sw_file_we;
	assign mem_waddr = exec_file_we ? cur_addr : bus.addr[6:0];
	assign mem_wdata = exec_file_we ? result : bus.wdata;

	bbx_file_mem u_file_mem (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.re(mem_re),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// Accumulator
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc <= `BBX_ACC_RST;
		end else if (exec_acc_we) begin
			acc <= result;
		end else if (sw_acc_we) begin
			acc <= bus.wdata;
		end
	end

	// Flags view; each bit has one owning process so no field is driven twice
	assign flags = {flag_ill, flag_z, flag_dc, flag_c};

	// Arithmetic flags: execution update beats a software write
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			{flag_z, flag_dc, flag_c} <= 3'(`BBX_FLAGS_RST);
		end else if (exec && (cur_op == bbx_pkg::OP_ADD)) begin
			flag_c <= sum9[8];
			flag_dc <= half5[4];
			flag_z <= (sum9[7:0] == 8'h00);
		end else if (exec && (cur_op == bbx_pkg::OP_AND)) begin
			flag_z <= (and_v == 8'h00);
		end else if (sw_flags_we) begin
			flag_c <= bus.wdata[`BBX_FLAG_C];
			flag_dc <= bus.wdata[`BBX_FLAG_DC];
			flag_z <= bus.wdata[`BBX_FLAG_Z];
		end
	end

	// Sticky unknown-opcode flag; write one clears it, a new event wins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_ill <= 1'b0;
		end else if (exec && (cur_op == bbx_pkg::OP_NONE)) begin
			flag_ill <= 1'b1;
		end else if (sw_flags_we && bus.wdata[`BBX_FLAG_ILL]) begin
			flag_ill <= 1'b0;
		end
	end

	// Count of recognised operations executed, wraps at 256
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_count <= `BBX_COUNT_RST;
		end else if (exec && (cur_op != bbx_pkg::OP_NONE)) begin
			op_count <= op_count + 8'h01;
		end
	end

	// Register read data; unmapped addresses read zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			rd_file <= 1'b0;
		end else begin
			rd_file <= bus.rd && is_file(bus.addr);
			if (bus.rd) begin
				unique case (bus.addr)
					`BBX_REG_ACC: reg_rdata <= acc;
					`BBX_REG_FLAGS: reg_rdata <= {4'h0, flags};
					`BBX_REG_COUNT: reg_rdata <= op_count;
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Both sources are flops; the mux keeps the file read on the memory register
	assign rd_data = rd_file ? mem_rdata : reg_rdata;

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	logic [8:0] chk_sum;
	logic [4:0] chk_half;
	logic [7:0] chk_mask;
	logic chk_sw_flags;
	assign chk_sum = 9'(acc) + 9'(mem_rdata);
	assign chk_half = 5'(acc[3:0]) + 5'(mem_rdata[3:0]);
	assign chk_mask = 8'h01 << cur_bpos;
	assign chk_sw_flags = bus.wr && (bus.addr == `BBX_REG_FLAGS);

	sequence s_accept;
		instr.valid && instr_ready;
	endsequence

	sequence s_run;
		(state == bbx_pkg::ST_EXEC) ##1 (op_done && state == bbx_pkg::ST_IDLE && instr_ready
			|| op_done && bus.rd && is_file(bus.addr));
	endsequence

	sequence s_exec_of(bbx_pkg::bbx_op_t o);
		exec && cur_op == o;
	endsequence

	chk_add_flags: assert property (s_exec_of(bbx_pkg::OP_ADD) |=>
		flags.c == $past(chk_sum[8]) && flags.dc == $past(chk_half[4]) &&
		flags.z == ($past(chk_sum[7:0]) == 8'h00))
		else $error("add flags wrong");

	chk_byte_dest: assert property (exec && byte_op |->
		if (cur_dest) (mem_we && mem_waddr == cur_addr && !exec_acc_we)
		else (!exec_file_we ##1 acc == $past(result)))
		else $error("byte result in wrong destination");

	chk_and_flags: assert property (s_exec_of(bbx_pkg::OP_AND) |=>
		flags.z == ($past(acc & mem_rdata) == 8'h00) &&
		flags.c == $past(flags.c) && flags.dc == $past(flags.dc))
		else $error("and flags wrong");

	chk_clr_bit: assert property (s_exec_of(bbx_pkg::OP_CLR) ##0 !chk_sw_flags |->
		mem_we && mem_wdata == (mem_rdata & ~chk_mask) ##1 $stable(flags[2:0]))
		else $error("bit clear wrong");

	chk_set_bit: assert property (s_exec_of(bbx_pkg::OP_SET) ##0 !chk_sw_flags |->
		mem_we && mem_wdata == (mem_rdata | chk_mask) ##1 $stable(flags[2:0]))
		else $error("bit set wrong");

	chk_field_take: assert property (s_accept |=>
		cur_addr == $past(instr.word[6:0]) && cur_bpos == $past(instr.word[9:7]) &&
		mem_rdata == $past(u_file_mem.mem[instr.word[6:0]]))
		else $error("operand fields wrong");

	chk_one_cycle: assert property (s_accept |=> s_run)
		else $error("operation not done in time");

endmodule

// ===== inc/bbx_defs.svh
`ifndef BBX_DEFS_SVH
`define BBX_DEFS_SVH

// Instruction word layout
`define BBX_IW 14
`define BBX_OPC_MSB 13
`define BBX_OPC_LSB 8
`define BBX_BOPC_LSB 10
`define BBX_DEST_BIT 7
`define BBX_ADDR_MSB 6
`define BBX_BPOS_MSB 9
`define BBX_BPOS_LSB 7

// Opcode patterns
`define BBX_OPC_ADD 6'h07
`define BBX_OPC_AND 6'h05
`define BBX_BOPC_CLR 4'h4
`define BBX_BOPC_SET 4'h5

// Register port map; address bit 7 selects the file register space
`define BBX_REG_ACC 8'h00
`define BBX_REG_FLAGS 8'h01
`define BBX_REG_COUNT 8'h02
`define BBX_FILE_SEL_BIT 7

// Flag bit positions in the flags register
`define BBX_FLAG_C 0
`define BBX_FLAG_DC 1
`define BBX_FLAG_Z 2
`define BBX_FLAG_ILL 3

// Reset values
`define BBX_ACC_RST 8'h00
`define BBX_FLAGS_RST 4'h0
`define BBX_COUNT_RST 8'h00

// Core clocks from accepting an instruction to its results being visible
`define BBX_EXEC_CYCLES 2

`endif

// ===== inc/bbx_pkg.sv
package bbx_pkg;

	// Sequencer states
	typedef enum logic [0:0] {ST_IDLE, ST_EXEC} bbx_state_t;

	// Decoded operation
	typedef enum logic [2:0] {OP_NONE, OP_ADD, OP_AND, OP_CLR, OP_SET} bbx_op_t;

	// Instruction offered by the decoder
	typedef struct packed {
		logic valid;
		logic [13:0] word;
	} bbx_req_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bbx_bus_t;

	// Status flags, low nibble of the flags register
	typedef struct packed {
		logic ill;
		logic z;
		logic dc;
		logic c;
	} bbx_flags_t;

endpackage

// ===== logic/bbx_file_mem.sv
`timescale 1ns/1ps

// File register space, 128 bytes, registered read data
module bbx_file_mem (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Write port
	input wire logic we,
	input wire logic [6:0] waddr,
	input wire logic [7:0] wdata,
	// Read port
	input wire logic re,
	input wire logic [6:0] raddr,
	output logic [7:0] rdata
);

	logic [7:0] mem [0:127];

	// Array holds no reset so it maps onto plain storage
	always_ff @(posedge core_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read data held until the next read
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (re) begin
			rdata <= mem[raddr];
		end
	end

endmodule

// ===== sim/bbx_dec_model.sv
`timescale 1ns/1ps

// Decoder model: offers one instruction and holds it until the unit takes it
module bbx_dec_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Bench side
	input wire logic issue,
	input wire logic [13:0] issue_word,
	// Unit side
	input wire logic instr_ready,
	output bbx_pkg::bbx_req_t instr
);
	// Word is inverted once taken, so a stale value never passes for a fresh one
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			instr <= '0;
		end else if (issue) begin
			instr <= {1'b1, issue_word};
		end else if (instr.valid && instr_ready) begin
			instr <= {1'b0, ~instr.word};
		end
	end
endmodule

// ===== sim/byte_and_bit_execute_unit_test.sv
`timescale 1ns/1ps

module byte_and_bit_execute_unit_test;
	// Operation, preset operands, expected acc, file and flags
	typedef struct {
		logic [13:0] w;
		logic [7:0] acc;
		logic [7:0] fil;
		logic [7:0] eacc;
		logic [7:0] efil;
		logic [7:0] efl;
	} bbx_row_t;

	logic core_clk;
	logic rst_n;
	logic issue;
	logic [13:0] issue_word;
	bbx_pkg::bbx_req_t instr;
	logic instr_ready;
	logic op_done;
	bbx_pkg::bbx_bus_t bus;
	logic [7:0] rd_data;
	int err_count;
	int checks;

	// Flags are not cleared between rows, so each row inherits the last
	bbx_row_t rows [9] = '{
		'{14'h0705, 8'h17, 8'hC2, 8'hD9, 8'hC2, 8'h00},
		'{14'h07FF, 8'h88, 8'h78, 8'h88, 8'h00, 8'h07},
		'{14'h05A2, 8'h17, 8'hC2, 8'h17, 8'h02, 8'h03},
		'{14'h0511, 8'hF0, 8'h0F, 8'h00, 8'h0F, 8'h07},
		'{14'h0700, 8'h0F, 8'h01, 8'h10, 8'h01, 8'h02},
		'{14'h13B3, 8'h55, 8'hC7, 8'h55, 8'h47, 8'h02},
		'{14'h1780, 8'h55, 8'h0A, 8'h55, 8'h8A, 8'h02},
		'{14'h107F, 8'h55, 8'hFF, 8'h55, 8'hFE, 8'h02},
		'{14'h15C0, 8'h55, 8'h00, 8'h55, 8'h08, 8'h02}
	};

	bbx_exec_unit i_bbx_exec_unit (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.instr(instr),
		.instr_ready(instr_ready),
		.op_done(op_done),
		.bus(bus),
		.rd_data(rd_data)
	);

	bbx_dec_model i_bbx_dec_model (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.issue(issue),
		.issue_word(issue_word),
		.instr_ready(instr_ready),
		.instr(instr)
	);

	// Clock at 40 MHz
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One write cycle on the register port
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask

	// File read data only stand in the cycle after the strobe; register read data hold until the next read
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1;
		cmp(rd_data, exp);
	endtask

	// Offer one instruction and wait, bounded, for completion
	task automatic run(input logic [13:0] w);
		int n;
		@(posedge core_clk);
		issue <= 1'b1;
		issue_word <= w;
		@(posedge core_clk);
		issue <= 1'b0;
		n = 0;
		while (op_done !== 1'b1 && n < 8) begin
			@(posedge core_clk);
			#1;
			n++;
			if (n == 1) begin
				cmp(8'(instr_ready), 8'h00);
			end
		end
		cmp(8'(n), 8'h02);
		cmp(8'(instr_ready), 8'h01);
	endtask

	task automatic stop_test();
		if (err_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#50us;
		err_count++;
		$display("FAIL %0t got %h exp %h", $time, 1'b0, 1'b1);
		stop_test();
	end

	initial begin
		rst_n = 1'b0;
		issue = 1'b0;
		issue_word = 14'h0000;
		bus = '0;
		err_count = 0;
		checks = 0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			wr(8'h00, rows[i].acc);
			wr({1'b1, rows[i].w[6:0]}, rows[i].fil);
			run(rows[i].w);
			rd(8'h00, rows[i].eacc);
			rd({1'b1, rows[i].w[6:0]}, rows[i].efil);
			rd(8'h01, rows[i].efl);
		end
		rd(8'h02, 8'h09);
		// Unknown opcode must write nothing
		wr(8'hFF, 8'h5A);
		run(14'h3FFF);
		rd(8'hFF, 8'h5A);
		rd(8'h01, 8'h0A);
		// Dependent pair: the bit op must see the sum written just before
		wr(8'h00, 8'h01);
		wr(8'h90, 8'hFF);
		run(14'h0790);
		run(14'h1510);
		rd(8'h90, 8'h04);
		rd(8'h01, 8'h0F);
		// Flags write: a one in bit 3 clears the unknown-opcode mark
		wr(8'h01, 8'h0D);
		rd(8'h01, 8'h05);
		// A new unknown opcode beats a clear landing in its execute cycle
		fork
			run(14'h3FFF);
			begin
				repeat (2) @(posedge core_clk);
				wr(8'h01, 8'h08);
			end
		join
		rd(8'h01, 8'h08);
		// Unmapped and read-only places
		rd(8'h03, 8'h00);
		wr(8'h02, 8'hAA);
		rd(8'h02, 8'h0B);
		// Second reset in mid-run
		@(posedge core_clk);
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		cmp(8'(op_done), 8'h00);
		cmp(8'(instr_ready), 8'h01);
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h00);
		stop_test();
	end
endmodule
